// >>> logic/i2r_top.sv
/* register block of the two-wire controller: own address, data/command
   port, clock period counts, masked status and mask, one interrupt.
   assumes protocol engine, fifos and enable bit outside on core_clk_i */
// How it works
// - own address and clock counts writable only while controller disabled
// - ten-bit own address resets 055h; seven-bit mode compares low bits
// - port write pushes command plus byte; read returns eight bits only
// - as master, command bit 8 picks direction: 0 write, 1 read
// - slave receiver ignores command; slave transmitter sends command-0 entries
// - read command after general call aborts unless special bit cleared
// - read command while answering a slave read raises transmit abort
// - master read colliding with remote addressing drops write, aborts
// - read command data bits ignored; port read returns received byte
// - high count sixteen bits, resets 0008h, 0009h recommended
// - low count sixteen bits, resets 000ah
// - masked status is raw gated by mask; zero after reset
// - sticky event cleared by reading its clear register or combined clear
// - mask one routes event to interrupt, zero blocks it
// - twelve event positions, general call at 11 down to underflow 0
// - mask resets enabled except start, stop and activity
// - receive underflow mask resets to one
// - raw events recorded whether masked or not
// - transmit abort flushes both fifos
// - slave read request holds serial clock low until data written
`timescale 1ns/1ps
`include "i2r_defs.svh"
module i2r_top import i2r_pkg::*; (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  input wire logic ctrl_enable_i,
  input wire i2r_role_type role_i,
  input wire logic general_call_event_mode_i,
  input wire logic [11:0] event_set_i,
  input wire logic [11:0] event_level_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_empty_i,
  input wire logic tx_full_i,
  input wire logic [9:0] bus_addr_i,
  input wire logic addr10_mode_i,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_n_o,
  output logic tx_push_o,
  output logic [8:0] tx_entry_o,
  output logic rx_pop_o,
  output logic fifo_flush_o,
  output logic [9:0] own_slave_address_o,
  output logic [15:0] clock_high_count_o,
  output logic [15:0] clock_low_count_o,
  output logic addr_match_o,
  output logic [11:0] masked_event_status_o,
  output logic irq_o
);
  i2r_top_type q, d;
  i2r_reg_if reg_bus ();
  logic [11:0] ev_raw;
  logic [11:0] ev_set;
  logic [11:0] ev_clr;
  logic [11:0] mis_q;
  logic wr_data_port;
  logic rd_data_port;
  logic cmd;
  logic abort;
  logic cfg_open;

  // byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = new_v[8*i +: 8];
    end
    return r;
  endfunction

  // which event a read of an individual clear register clears
  function automatic logic [11:0] clr_of(input logic [7:0] ofs);
    logic [11:0] m;
    m = '0;
    unique case (ofs)
      8'h44: m[0] = 1'b1;
      8'h48: m[1] = 1'b1;
      8'h4c: m[3] = 1'b1;
      8'h50: m[5] = 1'b1;
      8'h54: m[6] = 1'b1;
      8'h58: m[7] = 1'b1;
      8'h5c: m[8] = 1'b1;
      8'h60: m[9] = 1'b1;
      8'h64: m[10] = 1'b1;
      8'h68: m[11] = 1'b1;
      default: m = '0;
    endcase
    return m;
  endfunction

  i2r_axil u_axil (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .awaddr_i(awaddr_i),
    .awvalid_i(awvalid_i),
    .awready_o(awready_o),
    .wdata_i(wdata_i),
    .wstrb_i(wstrb_i),
    .wvalid_i(wvalid_i),
    .wready_o(wready_o),
    .bvalid_o(bvalid_o),
    .bready_i(bready_i),
    .araddr_i(araddr_i),
    .arvalid_i(arvalid_i),
    .arready_o(arready_o),
    .rdata_o(rdata_o),
    .rvalid_o(rvalid_o),
    .rready_i(rready_i),
    .rb(reg_bus.bus)
  );

  i2r_event u_event (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .set_i(ev_set),
    .level_i(event_level_i),
    .clr_i(ev_clr),
    .mask_i(q.mask),
    .raw_o(ev_raw),
    .irq_o(irq_o)
  );

  // every register answers okay; unmapped reads give zero
  assign bresp_o = 2'b00;
  assign rresp_o = 2'b00;

  // outputs straight from state
  assign serial_clock_pin_o = q.scl_out;
  assign serial_clock_pin_oe_n_o = !q.hold;
  assign tx_push_o = q.tx_push;
  assign tx_entry_o = q.tx_entry;
  assign rx_pop_o = q.rx_pop;
  assign fifo_flush_o = q.flush;
  assign own_slave_address_o = q.own_addr;
  assign clock_high_count_o = q.hcnt;
  assign clock_low_count_o = q.lcnt;
  assign addr_match_o = q.match;
  assign masked_event_status_o = mis_q;

  // masked status kept as a flop so the port comes from a register
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) mis_q <= '0;
    else mis_q <= ev_raw & q.mask;
  end

  // port access decode
  assign wr_data_port = reg_bus.wr_en && reg_bus.wr_addr == `I2R_OFS_DATA;
  assign rd_data_port = reg_bus.rd_en && reg_bus.rd_addr == `I2R_OFS_DATA;
  assign cmd = reg_bus.wr_data[`I2R_CMD_BIT];
  assign cfg_open = !ctrl_enable_i;

  // read command refused after general call or while a slave read is pending
  assign abort = wr_data_port && !tx_full_i && cmd && role_i != ROLE_SLAVE_RX &&
                 (general_call_event_mode_i || ev_raw[`I2R_EV_RD_REQ]);

  // hardware events of this block join those of the engine
  always_comb begin
    ev_set = event_set_i;
    if (abort) ev_set[`I2R_EV_TX_ABORT] = 1'b1;
    if (wr_data_port && tx_full_i) ev_set[`I2R_EV_TX_OVER] = 1'b1;
    if (rd_data_port && rx_empty_i) ev_set[`I2R_EV_RX_UNDER] = 1'b1;
    if (q.scl_sync != q.scl_prev) ev_set[`I2R_EV_ACTIVITY] = 1'b1;
  end

  // clear registers act on read, the combined one on every sticky event
  always_comb begin
    ev_clr = '0;
    if (reg_bus.rd_en) begin
      if (reg_bus.rd_addr == `I2R_OFS_CLR_ALL) ev_clr = '1;
      else ev_clr = clr_of(reg_bus.rd_addr);
    end
  end

  // read mux; reserved bits are zero by construction
  always_comb begin
    reg_bus.rd_data = '0;
    unique case (reg_bus.rd_addr)
      `I2R_OFS_OWN: reg_bus.rd_data[9:0] = q.own_addr;
      `I2R_OFS_DATA: reg_bus.rd_data[7:0] = rx_data_i;
      `I2R_OFS_HCNT: reg_bus.rd_data[15:0] = q.hcnt;
      `I2R_OFS_LCNT: reg_bus.rd_data[15:0] = q.lcnt;
      `I2R_OFS_MIS: reg_bus.rd_data[11:0] = ev_raw & q.mask;
      `I2R_OFS_MASK: reg_bus.rd_data[11:0] = q.mask;
      `I2R_OFS_RIS: reg_bus.rd_data[11:0] = ev_raw;
      default: reg_bus.rd_data = '0;
    endcase
  end

  // next state of the register file and fifo strobes
  always_comb begin
    logic [31:0] mw;
    logic [31:0] m_own;
    logic [31:0] m_hcnt;
    logic [31:0] m_lcnt;
    logic [31:0] m_mask;
    mw = merge(32'h0000_0000, reg_bus.wr_data, reg_bus.wr_strb);
    // merged words kept whole; a call result cannot be sliced directly
    m_own = merge({22'h0, q.own_addr}, reg_bus.wr_data, reg_bus.wr_strb);
    m_hcnt = merge({16'h0, q.hcnt}, reg_bus.wr_data, reg_bus.wr_strb);
    m_lcnt = merge({16'h0, q.lcnt}, reg_bus.wr_data, reg_bus.wr_strb);
    m_mask = merge({20'h0, q.mask}, reg_bus.wr_data, reg_bus.wr_strb);
    d = q;
    d.tx_push = 1'b0;
    d.rx_pop = 1'b0;
    d.scl_out = 1'b0;
    // serial clock pin: two flops, then the edge compare
    d.scl_meta = serial_clock_pin_i;
    d.scl_sync = q.scl_meta;
    d.scl_prev = q.scl_sync;
    // configuration locked while the controller runs
    if (reg_bus.wr_en && cfg_open) begin
      unique case (reg_bus.wr_addr)
        `I2R_OFS_OWN: d.own_addr = m_own[9:0];
        `I2R_OFS_HCNT: d.hcnt = m_hcnt[15:0];
        `I2R_OFS_LCNT: d.lcnt = m_lcnt[15:0];
        default: d.own_addr = q.own_addr;
      endcase
    end
    // the mask stays writable at any time
    if (reg_bus.wr_en && reg_bus.wr_addr == `I2R_OFS_MASK) begin
      d.mask = m_mask[11:0];
    end
    // data port write: one push unless full or refused
    if (wr_data_port && !tx_full_i && !abort) begin
      d.tx_push = 1'b1;
      if (role_i == ROLE_MASTER && cmd) begin
        d.tx_entry = {1'b1, 8'h00};
      end else begin
        d.tx_entry = {1'b0, mw[7:0]};
      end
      // written data releases a stretched clock
      if (role_i != ROLE_MASTER || !cmd) d.hold = 1'b0;
    end
    // data port read pops one entry if there is one
    if (rd_data_port && !rx_empty_i) d.rx_pop = 1'b1;
    // remote read request stretches the serial clock
    if (event_set_i[`I2R_EV_RD_REQ]) d.hold = 1'b1;
    // any abort empties both fifos
    d.flush = ev_set[`I2R_EV_TX_ABORT];
    // own address compare, low seven bits in seven-bit mode
    if (addr10_mode_i) d.match = bus_addr_i == q.own_addr;
    else d.match = bus_addr_i[6:0] == q.own_addr[6:0];
  end

  // state register of the module; the masked status flop mis_q is the only other one
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
      q.own_addr <= `I2R_RST_OWN;
      q.hcnt <= `I2R_RST_HCNT;
      q.lcnt <= `I2R_RST_LCNT;
      q.mask <= `I2R_RST_MASK;
      q.scl_meta <= 1'b1;
      q.scl_sync <= 1'b1;
      q.scl_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_cfg_lock;
    reg_bus.wr_en && reg_bus.wr_addr == `I2R_OFS_HCNT && ctrl_enable_i |=> $stable(clock_high_count_o);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("high count changed while enabled");

  property p_match7;
    !addr10_mode_i && bus_addr_i[6:0] == own_slave_address_o[6:0] && $stable(own_slave_address_o)
      |=> addr_match_o;
  endproperty
  a_match7: assert property (p_match7) else $error("seven-bit compare missed");

  property p_read_low8;
    rd_data_port |-> reg_bus.rd_data[31:8] == 24'h0 && reg_bus.rd_data[7:0] == rx_data_i;
  endproperty
  a_read_low8: assert property (p_read_low8) else $error("data port read wider than a byte");

  property p_rdcmd_data;
    tx_push_o && tx_entry_o[8] |-> tx_entry_o[7:0] == 8'h00 && $past(role_i) == ROLE_MASTER;
  endproperty
  a_rdcmd_data: assert property (p_rdcmd_data) else $error("read command carried data");

  property p_gc_abort;
    wr_data_port && cmd && general_call_event_mode_i && !tx_full_i && role_i == ROLE_MASTER
      |=> ev_raw[`I2R_EV_TX_ABORT] && !tx_push_o ##1 ev_raw[`I2R_EV_TX_ABORT];
  endproperty
  a_gc_abort: assert property (p_gc_abort) else $error("general call read did not abort");

  property p_flush;
    abort |=> fifo_flush_o ##1 !fifo_flush_o || $past(ev_set[`I2R_EV_TX_ABORT]);
  endproperty
  a_flush: assert property (p_flush) else $error("abort without flush");

  property p_irq;
    ##2 irq_o == $past(|(ev_raw & q.mask));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt does not follow masked events");

  property p_clr;
    ev_clr[7] && !ev_set[7] |=> !ev_raw[7];
  endproperty
  a_clr: assert property (p_clr) else $error("event survived its clear read");

  property p_hold;
    event_set_i[`I2R_EV_RD_REQ] |=> !serial_clock_pin_oe_n_o && !serial_clock_pin_o;
  endproperty
  a_hold: assert property (p_hold) else $error("clock not held on read request");

  property p_push;
    wr_data_port && !tx_full_i && !abort |=> tx_push_o ##1 !tx_push_o || $past(wr_data_port);
  endproperty
  a_push: assert property (p_push) else $error("port write not pushed once");

  c_abort: cover property (abort);
  c_hold_release: cover property (!serial_clock_pin_oe_n_o ##1 serial_clock_pin_oe_n_o);
  c_underflow: cover property (rd_data_port && rx_empty_i ##1 ev_raw[0]);
endmodule // i2r_top

// >>> inc/i2r_defs.svh
/* register map, reset values and event positions of the
   two-wire controller register block; no surroundings assumed */
`ifndef I2R_DEFS_SVH
`define I2R_DEFS_SVH
`define I2R_OFS_OWN 8'h08
`define I2R_OFS_DATA 8'h10
`define I2R_OFS_HCNT 8'h14
`define I2R_OFS_LCNT 8'h18
`define I2R_OFS_MIS 8'h2c
`define I2R_OFS_MASK 8'h30
`define I2R_OFS_RIS 8'h34
`define I2R_OFS_CLR_ALL 8'h40
`define I2R_OFS_CLR_LO 8'h44
`define I2R_OFS_CLR_HI 8'h68
`define I2R_RST_OWN 10'h055
`define I2R_RST_HCNT 16'h0008
`define I2R_RST_LCNT 16'h000a
`define I2R_RST_MASK 12'h8ff
`define I2R_STICKY 12'hfeb
`define I2R_CMD_BIT 8
`define I2R_EV_RX_UNDER 0
`define I2R_EV_TX_OVER 3
`define I2R_EV_RD_REQ 5
`define I2R_EV_TX_ABORT 6
`define I2R_EV_ACTIVITY 8
`endif

// >>> inc/i2r_pkg.sv
/* types of the register block; assumes i2r_defs.svh alongside */
package i2r_pkg;
  typedef enum logic [1:0] {
    ROLE_IDLE = 2'b00,
    ROLE_MASTER = 2'b01,
    ROLE_SLAVE_RX = 2'b10,
    ROLE_SLAVE_TX = 2'b11
  } i2r_role_type;
  typedef struct packed {
    logic aw_have; logic w_have; logic [7:0] awaddr; logic [31:0] wdata;
    logic [3:0] wstrb; logic bvalid; logic rvalid; logic [31:0] rdata;
  } i2r_axil_type;
  typedef struct packed {
    logic [11:0] raw; logic irq;
  } i2r_event_type;
  typedef struct packed {
    logic [9:0] own_addr; logic [15:0] hcnt; logic [15:0] lcnt;
    logic [11:0] mask; logic tx_push; logic [8:0] tx_entry; logic rx_pop;
    logic flush; logic hold; logic match; logic scl_meta; logic scl_sync;
    logic scl_prev; logic scl_out;
  } i2r_top_type;
endpackage

// >>> inc/i2r_reg_if.sv
/* register access strobes between bus slave and register file;
   one clock domain, strobes last one cycle */
`timescale 1ns/1ps
interface i2r_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input rd_data);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output rd_data);
endinterface // i2r_reg_if

// >>> logic/i2r_axil.sv
/* AXI4-Lite slave turning bus transfers into register strobes;
   assumes rd_data is valid in the cycle of rd_en */
`timescale 1ns/1ps
module i2r_axil import i2r_pkg::*; (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  input wire logic rready_i,
  i2r_reg_if.bus rb
);
  i2r_axil_type q, d;
  logic go;
  // ready flags are state bits, so they come from flops
  assign awready_o = !q.aw_have;
  assign wready_o = !q.w_have;
  assign arready_o = !q.rvalid;
  assign bvalid_o = q.bvalid;
  assign rvalid_o = q.rvalid;
  assign rdata_o = q.rdata;
  assign go = q.aw_have && q.w_have && !q.bvalid;
  assign rb.wr_en = go;
  assign rb.wr_addr = q.awaddr;
  assign rb.wr_data = q.wdata;
  assign rb.wr_strb = q.wstrb;
  assign rb.rd_en = arvalid_i && !q.rvalid;
  assign rb.rd_addr = araddr_i;
  // address and data taken in either order, response after both
  always_comb begin
    d = q;
    if (awvalid_i && !q.aw_have) begin
      d.aw_have = 1'b1;
      d.awaddr = awaddr_i;
    end
    if (wvalid_i && !q.w_have) begin
      d.w_have = 1'b1;
      d.wdata = wdata_i;
      d.wstrb = wstrb_i;
    end
    if (go) begin
      d.bvalid = 1'b1;
    end
    if (q.bvalid && bready_i) begin
      d.bvalid = 1'b0;
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
    end
    if (rb.rd_en) begin
      d.rvalid = 1'b1;
      d.rdata = rb.rd_data;
    end else if (q.rvalid && rready_i) begin
      d.rvalid = 1'b0;
    end
  end
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) q <= '0;
    else q <= d;
  end
endmodule // i2r_axil

// >>> logic/i2r_event.sv
/* sticky raw events, mask gating, single interrupt output;
   set and clear are one-cycle pulses of the core clock */
`timescale 1ns/1ps
`include "i2r_defs.svh"
module i2r_event import i2r_pkg::*; (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [11:0] set_i,
  input wire logic [11:0] level_i,
  input wire logic [11:0] clr_i,
  input wire logic [11:0] mask_i,
  output logic [11:0] raw_o,
  output logic irq_o
);
  i2r_event_type q, d;
  assign raw_o = q.raw;
  assign irq_o = q.irq;
  // set beats clear; fifo level bits simply follow their level
  always_comb begin
    d = q;
    d.raw = (((q.raw & ~clr_i) | set_i) & `I2R_STICKY) | (level_i & ~`I2R_STICKY);
    d.irq = |(q.raw & mask_i);
  end
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) q <= '0;
    else q <= d;
  end
endmodule // i2r_event

// >>> tb/i2r_remote.sv
/* remote bus party: drives the shared serial clock line in frames.
   assumes a pull-up on the line and the device's open-drain enable */
`timescale 1ns/1ps
module i2r_remote (
  input wire logic dev_oe_n_i,
  output logic scl_o
);
  logic pull_low;
  // wired-and line with pull-up; either party pulling low wins
  assign scl_o = !(pull_low || !dev_oe_n_i);
  initial begin
    pull_low = 1'b0;
  end
  // 160 ns per bit; line stands high between frames
  task automatic frame(input int bits);
    repeat (bits) begin
      pull_low = 1'b1;
      #80;
      pull_low = 1'b0;
      wait (scl_o === 1'b1);
      #80;
    end
  endtask
endmodule // i2r_remote

// >>> tb/test_i2c_addr_data_irq_regs.sv
/* self-checking bench of the register block over AXI4-Lite.
   assumes the design package, defines header and the remote model */
`timescale 1ns/1ps
`include "i2r_defs.svh"
module test_i2c_addr_data_irq_regs;
  import i2r_pkg::*;
  logic clk, resetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, rx_data;
  logic [31:0] wdata, rdata, got;
  logic [3:0] wstrb;
  logic ctrl_en, general_call_event, rx_empty, tx_full, addr10, scl, oe_n, push, pop, flush, match, irq, scl_drv;
  logic [11:0] ev_set, ev_level, mis;
  logic [9:0] bus_addr, own;
  logic [8:0] entry, last_entry;
  logic [15:0] hcnt, lcnt;
  i2r_role_type role;
  int bad_count = 0;
  int compares = 0;
  int pushes = 0;
  int pops = 0;
  int flushes = 0;
  int p0;

  i2r_top DUT (.core_clk_i(clk), .resetn_i(resetn), .awaddr_i(awaddr), .awvalid_i(awvalid),
    .awready_o(awready), .wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid), .wready_o(wready),
    .bresp_o(), .bvalid_o(bvalid), .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
    .arready_o(arready), .rdata_o(rdata), .rresp_o(), .rvalid_o(rvalid), .rready_i(rready),
    .ctrl_enable_i(ctrl_en), .role_i(role), .general_call_event_mode_i(general_call_event), .event_set_i(ev_set),
    .event_level_i(ev_level), .rx_data_i(rx_data), .rx_empty_i(rx_empty), .tx_full_i(tx_full),
    .bus_addr_i(bus_addr), .addr10_mode_i(addr10), .serial_clock_pin_i(scl), .serial_clock_pin_o(scl_drv),
    .serial_clock_pin_oe_n_o(oe_n), .tx_push_o(push), .tx_entry_o(entry), .rx_pop_o(pop),
    .fifo_flush_o(flush), .own_slave_address_o(own), .clock_high_count_o(hcnt), .clock_low_count_o(lcnt),
    .addr_match_o(match), .masked_event_status_o(mis), .irq_o(irq));

  i2r_remote far_end (.dev_oe_n_i(oe_n), .scl_o(scl));

  // 50 MHz core clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // one-cycle pulses are counted where settled, at the falling edge
  always @(negedge clk) begin
    if (push === 1'b1) begin
      pushes++;
      last_entry = entry;
    end
    if (pop === 1'b1) pops++;
    if (flush === 1'b1) flushes++;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic report_and_stop;
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ready is a flop, so its falling-edge value is what the next rising edge samples
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge clk);
      ta = ta || awready;
      tw = tw || wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b1;
    do begin
      @(negedge clk);
      tb = bvalid;
      @(posedge clk);
    end while (!tb);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic t;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
    end while (!t);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      t = rvalid;
      d = rdata;
      @(posedge clk);
    end while (!t);
    rready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask

  task automatic fire(input logic [11:0] b);
    ev_set <= b;
    @(posedge clk);
    ev_set <= 12'h000;
    idle(3);
  endtask

  // data port write in a given role; counts pushes and fifo flushes
  task automatic send(input i2r_role_type r, input logic [31:0] d, input int np, input int nf,
                      input logic [8:0] e);
    int f0, s0;
    s0 = pushes;
    f0 = flushes;
    role <= r;
    @(posedge clk);
    wr(`I2R_OFS_DATA, d);
    idle(3);
    chk(32'(pushes - s0), 32'(np));
    chk(32'(flushes - f0), 32'(nf));
    if (np > 0) chk({23'h0, last_entry}, {23'h0, e});
  endtask

  // main sequence
  initial begin
    resetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, ctrl_en, general_call_event, tx_full, addr10} = '0;
    {awaddr, araddr, wdata, rx_data, ev_set, ev_level, bus_addr} = '0;
    wstrb = 4'hf;
    rx_empty = 1'b1;
    role = ROLE_IDLE;
    idle(3);
    resetn <= 1'b1;
    @(posedge clk);
    rdc(`I2R_OFS_OWN, 32'h55);
    rdc(`I2R_OFS_HCNT, 32'h8);
    rdc(`I2R_OFS_LCNT, 32'ha);
    rdc(`I2R_OFS_MIS, 32'h0);
    rdc(`I2R_OFS_MASK, 32'h8ff);
    chk({31'h0, oe_n}, 32'h1);
    // enabled controller: writes must not land
    ctrl_en <= 1'b1;
    wr(`I2R_OFS_OWN, 32'h12);
    wr(`I2R_OFS_HCNT, 32'h20);
    wr(`I2R_OFS_LCNT, 32'h20);
    rdc(`I2R_OFS_OWN, 32'h55);
    rdc(`I2R_OFS_HCNT, 32'h8);
    rdc(`I2R_OFS_LCNT, 32'ha);
    ctrl_en <= 1'b0;
    wr(`I2R_OFS_OWN, 32'hffff_f2a5);
    wr(`I2R_OFS_HCNT, 32'hffff_0009);
    wr(`I2R_OFS_LCNT, 32'h0001_1234);
    rdc(`I2R_OFS_OWN, 32'h2a5);
    rdc(`I2R_OFS_HCNT, 32'h9);
    rdc(`I2R_OFS_LCNT, 32'h1234);
    chk({16'h0, hcnt}, 32'h9);
    chk({16'h0, lcnt}, 32'h1234);
    chk({22'h0, own}, 32'h2a5);
    rdc(8'h00, 32'h0);
    // seven-bit compare sees only the low bits
    bus_addr <= 10'h025;
    idle(3);
    chk({31'h0, match}, 32'h1);
    addr10 <= 1'b1;
    idle(3);
    chk({31'h0, match}, 32'h0);
    bus_addr <= 10'h2a5;
    idle(3);
    chk({31'h0, match}, 32'h1);
    ctrl_en <= 1'b1;
    send(ROLE_MASTER, 32'h1a5, 1, 0, 9'h100);
    send(ROLE_MASTER, 32'h0a5, 1, 0, 9'h0a5);
    send(ROLE_SLAVE_RX, 32'hffff_ffc3, 1, 0, 9'h0c3);
    send(ROLE_SLAVE_TX, 32'h03c, 1, 0, 9'h03c);
    // read request holds the clock until a data entry arrives
    fire(12'h020);
    chk({31'h0, oe_n}, 32'h0);
    chk({31'h0, scl_drv}, 32'h0);
    send(ROLE_SLAVE_TX, 32'h111, 0, 1, 9'h0);
    // the stretched clock line falling is itself bus activity
    rdc(`I2R_OFS_RIS, 32'h160);
    send(ROLE_MASTER, 32'h1ff, 0, 1, 9'h0);
    send(ROLE_SLAVE_TX, 32'h022, 1, 0, 9'h022);
    chk({31'h0, oe_n}, 32'h1);
    rdc(`I2R_OFS_CLR_ALL, 32'h0);
    rdc(`I2R_OFS_RIS, 32'h0);
    general_call_event <= 1'b1;
    send(ROLE_MASTER, 32'h100, 0, 1, 9'h0);
    general_call_event <= 1'b0;
    send(ROLE_MASTER, 32'h1ab, 1, 0, 9'h100);
    tx_full <= 1'b1;
    send(ROLE_MASTER, 32'h055, 0, 0, 9'h0);
    tx_full <= 1'b0;
    rdc(`I2R_OFS_RIS, 32'h048);
    // port reads pop the receive fifo; empty read flags underflow
    rx_data <= 8'h5a;
    rx_empty <= 1'b0;
    p0 = pops;
    rdc(`I2R_OFS_DATA, 32'h5a);
    chk(32'(pops - p0), 32'h1);
    rx_empty <= 1'b1;
    rd(`I2R_OFS_DATA, got);
    chk(32'(pops - p0), 32'h1);
    rdc(`I2R_OFS_RIS, 32'h049);
    rdc(`I2R_OFS_CLR_ALL, 32'h0);
    // masking and interrupt routing
    wr(`I2R_OFS_MASK, 32'hffff_f0f0);
    rdc(`I2R_OFS_MASK, 32'h0f0);
    ev_level <= 12'h014;
    fire(12'hfeb);
    rdc(`I2R_OFS_RIS, 32'hfff);
    rdc(`I2R_OFS_MIS, 32'h0f0);
    chk({20'h0, mis}, 32'h0f0);
    chk({31'h0, irq}, 32'h1);
    wr(`I2R_OFS_MASK, 32'h0);
    idle(3);
    chk({31'h0, irq}, 32'h0);
    rdc(`I2R_OFS_MIS, 32'h0);
    rdc(`I2R_OFS_CLR_LO, 32'h0);
    rdc(`I2R_OFS_RIS, 32'hffe);
    rdc(`I2R_OFS_CLR_ALL, 32'h0);
    rdc(`I2R_OFS_RIS, 32'h014);
    ev_level <= 12'h000;
    // release the clock held since the last read request, else the line never rises
    send(ROLE_SLAVE_TX, 32'h033, 1, 0, 9'h033);
    chk({31'h0, oe_n}, 32'h1);
    rdc(`I2R_OFS_CLR_ALL, 32'h0);
    // link clock edges mark bus activity
    far_end.frame(3);
    idle(4);
    rdc(`I2R_OFS_RIS, 32'h100);
    report_and_stop;
  end

  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    bad_count++;
    report_and_stop;
  end
endmodule // test_i2c_addr_data_irq_regs
